// ===== alid_decoder.sv
// alid_decoder: gathers opcode and operand bytes from program memory,
// decodes them and times execution in machine cycles.
// assumes: program memory sits on the core clock and offers bytes in order
// with a valid/ready handshake; the datapath obeys the decoded fields.
`timescale 1ns/1ps

module alid_decoder #(
  parameter int MC_CLOCKS = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // program memory byte stream
  input wire logic code_valid_in,
  input wire logic [7:0] code_byte_in,
  output logic code_ready_out,
  // decoded instruction to the datapath
  output logic instr_valid_out,
  output alid_pkg::alid_instr_s instr_out,
  output logic exec_busy_out,
  output logic exec_done_out
);

  localparam int CNT_W = $clog2(alid_pkg::CYC_MAX * MC_CLOCKS + 1);

  typedef struct packed {
    alid_pkg::alid_state_e state;
    logic [1:0] cnt;
    logic [7:0] op;
    logic [7:0] b2;
    logic [CNT_W-1:0] clk_cnt;
    logic start;
    logic done;
    alid_pkg::alid_instr_s instr;
  } alid_core_s;

  alid_core_s st_reg;
  alid_core_s st_next;

  // ==========================================================================
  // table lookups
  // ==========================================================================
  function automatic logic [3:0] col_idx(input logic [7:0] op);
    return op[3] ? alid_pkg::COL_REG_GRP : {1'b0, op[2:0]};
  endfunction

  function automatic logic [1:0] len_of(input logic [7:0] op);
    logic [3:0] c;
    c = col_idx(op);
    if (alid_pkg::LEN3_MASK[c][op[7:4]]) begin
      return alid_pkg::LEN_THREE;
    end
    if (alid_pkg::LEN2_MASK[c][op[7:4]]) begin
      return alid_pkg::LEN_TWO;
    end
    return alid_pkg::LEN_ONE;
  endfunction

  function automatic logic [2:0] cyc_of(input logic [7:0] op);
    logic [3:0] c;
    c = col_idx(op);
    if (op == alid_pkg::OP_MUL || op == alid_pkg::OP_DIV) begin
      return alid_pkg::CYC_MULDIV;
    end
    if (alid_pkg::CYC2_MASK[c][op[7:4]]) begin
      return alid_pkg::CYC_TWO;
    end
    return alid_pkg::CYC_ONE;
  endfunction

  // operand mode of columns 4 and up
  function automatic alid_pkg::alid_mode_e mode_of(input logic [3:0] c);
    unique case (c)
      4'h4: return alid_pkg::MODE_IMM;
      4'h5: return alid_pkg::MODE_DIR;
      4'h6, 4'h7: return alid_pkg::MODE_IND;
      4'h8: return alid_pkg::MODE_REG;
      default: return alid_pkg::MODE_NONE;
    endcase
  endfunction

  // ==========================================================================
  // full decode of one assembled instruction
  // ==========================================================================
  function automatic alid_pkg::alid_instr_s decode(input logic [7:0] op,
                                                   input logic [7:0] b2,
                                                   input logic [7:0] b3);
    alid_pkg::alid_instr_s d;
    logic [3:0] c;
    logic [3:0] row;
    logic [7:0] last;
    d = '0;
    c = col_idx(op);
    row = op[7:4];
    d.opcode = op;
    d.len = len_of(op);
    d.cycles = cyc_of(op);
    d.reg_sel = op[2:0];
    // pointer from register 0 or 1
    d.ptr_sel = op[0];
    d.ind_int = (c == 4'h6) || (c == 4'h7);
    // external moves use the pointer as an external address instead
    d.ind_ext = (row >= alid_pkg::ROW_EXT) && (c == 4'h2 || c == 4'h3);
    d.direct = b2;
    last = (d.len == alid_pkg::LEN_THREE) ? b3 : b2;
    d.imm = last;
    d.rel_ext = {{8{last[7]}}, last};
    d.addr11 = {op[7:5], b2};
    d.addr16 = {b2, b3};
    if (c >= 4'h4 && (row == alid_pkg::ROW_ADD || row == alid_pkg::ROW_ADD_WITH_CARRY ||
        row == alid_pkg::ROW_SUBTRACT_WITH_BORROW)) begin
      d.op = (row == alid_pkg::ROW_ADD) ? alid_pkg::ALID_ADD :
             (row == alid_pkg::ROW_ADD_WITH_CARRY) ? alid_pkg::ALID_ADD_WITH_CARRY : alid_pkg::ALID_SUBTRACT_WITH_BORROW;
      d.dst = alid_pkg::MODE_ACC;
      d.src = mode_of(c);
      d.cy_we = 1'b1;
      d.ac_we = 1'b1;
      d.ov_we = 1'b1;
    end
    // logic ops, direct targets written back
    if (c >= 4'h2 && (row == alid_pkg::ROW_OR || row == alid_pkg::ROW_AND ||
        row == alid_pkg::ROW_XOR)) begin
      d.op = (row == alid_pkg::ROW_OR) ? alid_pkg::ALID_OR :
             (row == alid_pkg::ROW_AND) ? alid_pkg::ALID_AND : alid_pkg::ALID_XOR;
      d.dst = (c < 4'h4) ? alid_pkg::MODE_DIR : alid_pkg::MODE_ACC;
      d.src = (c == 4'h2) ? alid_pkg::MODE_ACC :
              (c == 4'h3) ? alid_pkg::MODE_IMM : mode_of(c);
    end
    if (c >= 4'h4 && (row == alid_pkg::ROW_INC || row == alid_pkg::ROW_DEC)) begin
      d.op = (row == alid_pkg::ROW_INC) ? alid_pkg::ALID_INC : alid_pkg::ALID_DEC;
      d.dst = (c == 4'h4) ? alid_pkg::MODE_ACC : mode_of(c);
    end
    // single-opcode accumulator and pointer operations
    unique case (op)
      alid_pkg::OP_INC_DP: begin
        d.op = alid_pkg::ALID_INC_DP;
        d.dst = alid_pkg::MODE_DATA_POINTER;
      end
      alid_pkg::OP_MUL, alid_pkg::OP_DIV: begin
        d.op = (op == alid_pkg::OP_MUL) ? alid_pkg::ALID_MUL : alid_pkg::ALID_DIV;
        d.dst = alid_pkg::MODE_ACC;
        d.cy_we = 1'b1;
        d.ov_we = 1'b1;
      end
      alid_pkg::OP_DEC_ADJ: begin
        d.op = alid_pkg::ALID_DEC_ADJ;
        d.dst = alid_pkg::MODE_ACC;
        d.cy_we = 1'b1;
      end
      alid_pkg::OP_CLR_A, alid_pkg::OP_CPL_A: begin
        d.op = (op == alid_pkg::OP_CLR_A) ? alid_pkg::ALID_CLR : alid_pkg::ALID_CPL;
        d.dst = alid_pkg::MODE_ACC;
      end
      default: begin
      end
    endcase
    return d;
  endfunction

  // ==========================================================================
  // byte gathering and execution timing
  // ==========================================================================
  // one pass: bytes are taken only while idle, so an instruction in flight
  // stalls program memory instead of needing a prefetch buffer
  always_comb begin
    logic [7:0] op_v;
    logic [7:0] b2_v;
    logic [7:0] b3_v;
    logic [1:0] need;
    op_v = 8'h00;
    b2_v = 8'h00;
    b3_v = 8'h00;
    need = alid_pkg::LEN_ONE;
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.done = 1'b0;
    unique case (st_reg.state)
      alid_pkg::ST_FETCH: begin
        if (code_valid_in) begin
          op_v = (st_reg.cnt == 2'h0) ? code_byte_in : st_reg.op;
          need = len_of(op_v);
          if (st_reg.cnt == 2'h0) begin
            st_next.op = code_byte_in;
            st_next.b2 = 8'h00;
          end
          if (st_reg.cnt == 2'h1) begin
            st_next.b2 = code_byte_in;
          end
          st_next.cnt = st_reg.cnt + 2'h1;
          if (st_reg.cnt + 2'h1 == need) begin
            // a one-byte instruction must not inherit the previous operand byte
            b2_v = (st_reg.cnt == 2'h1) ? code_byte_in :
                   (st_reg.cnt == 2'h0) ? 8'h00 : st_reg.b2;
            b3_v = (st_reg.cnt == 2'h2) ? code_byte_in : 8'h00;
            st_next.instr = decode(op_v, b2_v, b3_v);
            st_next.cnt = 2'h0;
            st_next.state = alid_pkg::ST_EXEC;
            st_next.start = 1'b1;
            st_next.clk_cnt = CNT_W'(int'(cyc_of(op_v)) * MC_CLOCKS - 1);
          end
        end
      end
      alid_pkg::ST_EXEC: begin
        // hold for the instruction's machine cycles
        if (st_reg.clk_cnt == '0) begin
          st_next.state = alid_pkg::ST_FETCH;
          st_next.done = 1'b1;
        end else begin
          st_next.clk_cnt = st_reg.clk_cnt - CNT_W'(1);
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs: handshake combinational, data straight from flops
  assign code_ready_out = (st_reg.state == alid_pkg::ST_FETCH);
  assign instr_valid_out = st_reg.start;
  assign instr_out = st_reg.instr;
  assign exec_busy_out = (st_reg.state == alid_pkg::ST_EXEC);
  assign exec_done_out = st_reg.done;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic [7:0] busy_cnt;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_cnt <= 8'h00;
    end else if (exec_busy_out) begin
      busy_cnt <= busy_cnt + 8'h01;
    end else begin
      busy_cnt <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_issue(alid_pkg::alid_op_e o, alid_pkg::alid_mode_e m);
    instr_valid_out && instr_out.op == o && instr_out.src == m;
  endsequence
  sequence s_shape(logic [1:0] l, logic [2:0] y);
    instr_out.len == l && instr_out.cycles == y;
  endsequence

  a_arith_short: assert property ((s_issue(alid_pkg::ALID_ADD_WITH_CARRY, alid_pkg::MODE_REG) or
      s_issue(alid_pkg::ALID_SUBTRACT_WITH_BORROW, alid_pkg::MODE_IND)) |-> s_shape(2'h1, 3'h1))
    else $error("short arithmetic form has wrong size or time");
  a_add_wide: assert property ((s_issue(alid_pkg::ALID_ADD, alid_pkg::MODE_DIR) or
      s_issue(alid_pkg::ALID_ADD_WITH_CARRY, alid_pkg::MODE_IMM)) |-> s_shape(2'h2, 3'h1))
    else $error("wide add form has wrong size or time");
  a_subtract_with_borrow_wide: assert property (s_issue(alid_pkg::ALID_SUBTRACT_WITH_BORROW, alid_pkg::MODE_IMM)
      |-> s_shape(2'h2, 3'h1) and instr_out.cy_we)
    else $error("wide subtract form malformed");
  a_ind_pointer: assert property (s_issue(alid_pkg::ALID_ADD, alid_pkg::MODE_IND)
      |-> instr_out.ind_int && instr_out.ptr_sel == $past(code_byte_in[0])
      && instr_out.len == 2'h1)
    else $error("indirect add pointer wrong");
  a_ind_select: assert property (instr_valid_out && instr_out.ind_int
      |-> !instr_out.ind_ext && instr_out.ptr_sel == instr_out.opcode[0])
    else $error("indirect pointer select wrong");
  a_rel_signed: assert property (instr_valid_out && instr_out.len != 2'h1
      |-> instr_out.rel_ext == {{8{$past(code_byte_in[7])}}, $past(code_byte_in)})
    else $error("displacement not sign extended from last byte");
  a_long_target: assert property (instr_valid_out && instr_out.opcode == alid_pkg::OP_LONG_JMP
      |-> instr_out.addr16[7:0] == $past(code_byte_in))
    else $error("long target low byte wrong");
  a_short_target: assert property (instr_valid_out && instr_out.opcode[3:0] == 4'h1
      |-> instr_out.addr11 == {instr_out.opcode[7:5], $past(code_byte_in)})
    else $error("short target wrong");
  a_incdec_short: assert property (instr_valid_out && instr_out.op == alid_pkg::ALID_DEC
      && instr_out.dst != alid_pkg::MODE_DIR |-> s_shape(2'h1, 3'h1))
    else $error("short decrement malformed");
  a_incdec_dir: assert property (instr_valid_out && instr_out.op == alid_pkg::ALID_INC
      && instr_out.dst == alid_pkg::MODE_DIR |-> s_shape(2'h2, 3'h1))
    else $error("direct increment malformed");
  a_data_pointer_inc: assert property (instr_valid_out && instr_out.opcode == alid_pkg::OP_INC_DP
      |-> s_shape(2'h1, 3'h2) and instr_out.dst == alid_pkg::MODE_DATA_POINTER)
    else $error("pointer increment malformed");
  a_exec_time: assert property ($rose(exec_done_out)
      |-> busy_cnt == 8'(int'(instr_out.cycles) * MC_CLOCKS))
    else $error("execution length differs from cycle count");
  a_logic_dir: assert property (instr_valid_out && instr_out.dst == alid_pkg::MODE_DIR
      && instr_out.src == alid_pkg::MODE_ACC |-> s_shape(2'h2, 3'h1))
    else $error("logic into direct byte malformed");
  a_logic_imm: assert property (instr_valid_out && instr_out.dst == alid_pkg::MODE_DIR
      && instr_out.src == alid_pkg::MODE_IMM |-> s_shape(2'h3, 3'h2))
    else $error("immediate logic into direct byte malformed");
  a_flags_kept: assert property (instr_valid_out && instr_out.dst == alid_pkg::MODE_DIR
      |-> !instr_out.cy_we && !instr_out.ac_we && !instr_out.ov_we)
    else $error("direct logic op writes flags");
  a_muldiv_time: assert property (instr_valid_out && instr_out.op == alid_pkg::ALID_MUL
      |-> exec_busy_out [*4] ##1 exec_done_out || MC_CLOCKS != 1)
    else $error("multiply not four cycles");

endmodule

// ===== alid_pkg.sv
// alid_pkg: constants, enumerations and carriers for the arithmetic and
// logic instruction decoder.
// assumes: opcode encoding of the standard 8-bit controller family.
package alid_pkg;

  // ==========================================================================
  // opcode length and timing tables, one 16-bit row mask per column group
  // ==========================================================================
  // column groups: low nibble 0..7 map to 0..7, low nibble 8..F to group 8
  localparam int COLS = 9;
  localparam logic [3:0] COL_REG_GRP = 4'h8;
  // bit n set: opcode with high nibble n is at least two bytes long
  localparam logic [15:0] LEN2_MASK [COLS] = '{16'h3FFE, 16'hFFFF, 16'h3FF3,
    16'h0070, 16'h0AFC, 16'hFBFF, 16'h0D80, 16'h0D80, 16'h2D80};
  // bit n set: opcode with high nibble n is three bytes long
  localparam logic [15:0] LEN3_MASK [COLS] = '{16'h020E, 16'h0000, 16'h0003,
    16'h0070, 16'h0800, 16'h2980, 16'h0800, 16'h0800, 16'h0800};
  // bit n set: opcode with high nibble n takes two machine cycles
  localparam logic [15:0] CYC2_MASK [COLS] = '{16'hFFFE, 16'hFFFF, 16'hC38F,
    16'hC7F0, 16'h0800, 16'h2980, 16'h0D00, 16'h0D00, 16'h2D00};

  // ==========================================================================
  // opcode rows and single opcodes of interest
  // ==========================================================================
  localparam logic [3:0] ROW_INC = 4'h0;
  localparam logic [3:0] ROW_DEC = 4'h1;
  localparam logic [3:0] ROW_ADD = 4'h2;
  localparam logic [3:0] ROW_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] ROW_OR = 4'h4;
  localparam logic [3:0] ROW_AND = 4'h5;
  localparam logic [3:0] ROW_XOR = 4'h6;
  localparam logic [3:0] ROW_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] ROW_EXT = 4'hE;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_INC_DP = 8'hA3;
  localparam logic [7:0] OP_DEC_ADJ = 8'hD4;
  localparam logic [7:0] OP_CLR_A = 8'hE4;
  localparam logic [7:0] OP_CPL_A = 8'hF4;
  localparam logic [7:0] OP_LONG_JMP = 8'h02;

  // ==========================================================================
  // lengths and machine-cycle counts
  // ==========================================================================
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_MULDIV = 3'h4;
  localparam int CYC_MAX = 4;

  // ==========================================================================
  // enumerations and carriers
  // ==========================================================================
  typedef enum logic [3:0] {
    ALID_OTHER = 4'h0, ALID_ADD = 4'h1, ALID_ADD_WITH_CARRY = 4'h2, ALID_SUBTRACT_WITH_BORROW = 4'h3,
    ALID_INC = 4'h4, ALID_DEC = 4'h5, ALID_INC_DP = 4'h6, ALID_MUL = 4'h7,
    ALID_DIV = 4'h8, ALID_DEC_ADJ = 4'h9, ALID_AND = 4'hA, ALID_OR = 4'hB,
    ALID_XOR = 4'hC, ALID_CLR = 4'hD, ALID_CPL = 4'hE
  } alid_op_e;

  typedef enum logic [2:0] {
    MODE_NONE = 3'h0, MODE_ACC = 3'h1, MODE_REG = 3'h2, MODE_DIR = 3'h3,
    MODE_IND = 3'h4, MODE_IMM = 3'h5, MODE_DATA_POINTER = 3'h6
  } alid_mode_e;

  typedef enum logic [0:0] {
    ST_FETCH = 1'h0, ST_EXEC = 1'h1
  } alid_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    alid_op_e op;
    alid_mode_e src;
    alid_mode_e dst;
    logic [2:0] reg_sel;
    logic ptr_sel;
    logic ind_int;
    logic ind_ext;
    logic [7:0] direct;
    logic [7:0] imm;
    logic [15:0] rel_ext;
    logic [10:0] addr11;
    logic [15:0] addr16;
    logic [1:0] len;
    logic [2:0] cycles;
    logic cy_we;
    logic ac_we;
    logic ov_we;
  } alid_instr_s;

endpackage

// ===== alid_code_mem.sv
// alid_code_mem: program memory model that offers code bytes in order.
// assumes: the bench loads bytes through push at the falling clock edge.
`timescale 1ns/1ps
module alid_code_mem (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // handshake with the decoder
  input wire logic code_ready_in,
  input wire logic stall_in,
  output logic code_valid_out,
  output logic [7:0] code_byte_out
);
  logic [7:0] q[$];

  // ==========================================================================
  // byte queue and offer logic
  // ==========================================================================
  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction

  // an offered byte stays put until taken; stall models a slow memory
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q.delete();
      code_valid_out <= 1'b0;
      code_byte_out <= 8'h00;
    end else if (!code_valid_out || code_ready_in) begin
      if (code_valid_out) begin
        void'(q.pop_front());
      end
      if (q.size() != 0 && !stall_in) begin
        code_valid_out <= 1'b1;
        code_byte_out <= q[0];
      end else begin
        // idle line toggles so a stale byte can never pass as fresh
        code_valid_out <= 1'b0;
        code_byte_out <= ~code_byte_out;
      end
    end
  end
endmodule

// ===== alid_testbench.sv
// testbench: random and corner opcode streams into the decoder.
// assumes: one core clock, machine cycle of one clock (MC_CLOCKS = 1).
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [1:0] len;
    logic [2:0] cyc;
    logic [2:0] we;
    alid_pkg::alid_op_e op;
    alid_pkg::alid_mode_e src;
    alid_pkg::alid_mode_e dst;
  } alid_exp_s;

  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic stall = 1'b0;
  logic rnd_on = 1'b0;
  logic code_valid;
  logic [7:0] code_byte;
  logic code_ready;
  logic instr_valid;
  alid_pkg::alid_instr_s io;
  logic busy;
  logic done;
  alid_exp_s exp_q[$];
  alid_exp_s cur;
  logic [7:0] imm;
  int n_errors = 0;
  int cmp_count = 0;
  int nb = 0;
  int bc = 0;

  // ==========================================================================
  // clock, instances
  // ==========================================================================
  initial forever #25 clk_sys_in = ~clk_sys_in;

  alid_code_mem mem (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .code_ready_in(code_ready), .stall_in(stall),
    .code_valid_out(code_valid), .code_byte_out(code_byte));

  alid_decoder #(.MC_CLOCKS(1)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .code_valid_in(code_valid), .code_byte_in(code_byte),
    .code_ready_out(code_ready), .instr_valid_out(instr_valid),
    .instr_out(io), .exec_busy_out(busy), .exec_done_out(done));

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // operand mode from the low nibble of an arithmetic, logic or step opcode
  function automatic alid_pkg::alid_mode_e md_of(input logic [3:0] c);
    if (c == 4'h4) return alid_pkg::MODE_IMM;
    if (c == 4'h5) return alid_pkg::MODE_DIR;
    if (c == 4'h6 || c == 4'h7) return alid_pkg::MODE_IND;
    if (c >= 4'h8) return alid_pkg::MODE_REG;
    return alid_pkg::MODE_NONE;
  endfunction

  // length, timing and flag enables worked out per opcode
  function automatic alid_exp_s exp_of(input logic [7:0] o);
    alid_exp_s e;
    logic lg;
    e = '0;
    e.opc = o;
    e.len = alid_pkg::LEN_ONE;
    e.cyc = alid_pkg::CYC_ONE;
    lg = (o[7:4] >= 4'h4 && o[7:4] <= 4'h6);
    case (o[7:4])
      4'h0: e.op = alid_pkg::ALID_INC;
      4'h1: e.op = alid_pkg::ALID_DEC;
      4'h2: e.op = alid_pkg::ALID_ADD;
      4'h3: e.op = alid_pkg::ALID_ADD_WITH_CARRY;
      4'h9: e.op = alid_pkg::ALID_SUBTRACT_WITH_BORROW;
      4'h4: e.op = alid_pkg::ALID_OR;
      4'h5: e.op = alid_pkg::ALID_AND;
      4'h6: e.op = alid_pkg::ALID_XOR;
      default: e.op = alid_pkg::ALID_OTHER;
    endcase
    if (o[7:4] >= 4'h2 && o[7:4] <= 4'h3 || o[7:4] == 4'h9)
      e.we = 3'h7;
    if (e.op inside {alid_pkg::ALID_ADD, alid_pkg::ALID_ADD_WITH_CARRY, alid_pkg::ALID_SUBTRACT_WITH_BORROW}) begin
      e.dst = alid_pkg::MODE_ACC;
      e.src = md_of(o[3:0]);
    end
    if (lg) begin
      e.dst = (o[3:0] < 4'h4) ? alid_pkg::MODE_DIR : alid_pkg::MODE_ACC;
      e.src = (o[3:0] == 4'h2) ? alid_pkg::MODE_ACC :
        (o[3:0] == 4'h3) ? alid_pkg::MODE_IMM : md_of(o[3:0]);
    end
    if (e.op inside {alid_pkg::ALID_INC, alid_pkg::ALID_DEC})
      e.dst = (o[3:0] == 4'h4) ? alid_pkg::MODE_ACC : md_of(o[3:0]);
    if (o[3:0] == 4'h5 || (o[3:0] == 4'h4 && o[7:4] > 4'h1) || (lg && o[3:0] == 4'h2))
      e.len = alid_pkg::LEN_TWO;
    if (lg && o[3:0] == 4'h3) begin
      e.len = alid_pkg::LEN_THREE;
      e.cyc = alid_pkg::CYC_TWO;
    end
    case (o)
      8'hA3: begin
        e.op = alid_pkg::ALID_INC_DP;
        e.dst = alid_pkg::MODE_DATA_POINTER;
        e.len = alid_pkg::LEN_ONE;
        e.cyc = alid_pkg::CYC_TWO;
      end
      8'hA4, 8'h84: begin
        e.op = (o == 8'hA4) ? alid_pkg::ALID_MUL : alid_pkg::ALID_DIV;
        e.len = alid_pkg::LEN_ONE;
        e.cyc = alid_pkg::CYC_MULDIV;
        e.we = 3'h5;
        e.dst = alid_pkg::MODE_ACC;
      end
      8'hD4, 8'hE4, 8'hF4: begin
        e.op = (o == 8'hD4) ? alid_pkg::ALID_DEC_ADJ :
          (o == 8'hE4) ? alid_pkg::ALID_CLR : alid_pkg::ALID_CPL;
        e.len = alid_pkg::LEN_ONE;
        e.we = (o == 8'hD4) ? 3'h4 : 3'h0;
        e.dst = alid_pkg::MODE_ACC;
      end
      default: ;
    endcase
    return e;
  endfunction

  task automatic issue(input logic [7:0] o, input logic [7:0] b2, input logic [7:0] b3);
    alid_exp_s e;
    e = exp_of(o);
    e.b2 = b2;
    e.b3 = b3;
    @(negedge clk_sys_in);
    exp_q.push_back(e);
    mem.push(o);
    if (e.len > 2'h1) mem.push(b2);
    if (e.len == 2'h3) mem.push(b3);
  endtask

  task automatic drain;
    for (int k = 0; k < 6000 && (exp_q.size() != 0 || busy !== 1'b0); k++)
      @(posedge clk_sys_in);
    repeat (2) @(posedge clk_sys_in);
    chk("drained", exp_q.size(), 0);
  endtask

  // ==========================================================================
  // monitor: decoded fields, byte count and busy length
  // ==========================================================================
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      nb = 0;
      bc = 0;
    end else begin
      if (instr_valid === 1'b1) begin
        cur = exp_q.pop_front();
        imm = (cur.len == 2'h3) ? cur.b3 : (cur.len == 2'h2) ? cur.b2 : 8'h00;
        chk("opcode", io.opcode, cur.opc);
        chk("op", io.op, cur.op);
        chk("src", io.src, cur.src);
        chk("dst", io.dst, cur.dst);
        chk("len", io.len, cur.len);
        chk("bytes", nb, cur.len);
        chk("cycles", io.cycles, cur.cyc);
        chk("flag_we", {io.cy_we, io.ac_we, io.ov_we}, cur.we);
        chk("reg_sel", io.reg_sel, cur.opc[2:0]);
        chk("ptr_sel", io.ptr_sel, cur.opc[0]);
        chk("ind_int", io.ind_int, cur.opc[3:1] == 3'h3);
        chk("imm", io.imm, imm);
        chk("rel_ext", io.rel_ext, {{8{imm[7]}}, imm});
        if (cur.len > 2'h1) begin
          chk("direct", io.direct, cur.b2);
          chk("addr11", io.addr11, {cur.opc[7:5], cur.b2});
        end
        if (cur.len == 2'h3)
          chk("addr16", io.addr16, {cur.b2, cur.b3});
        nb = 0;
        bc = 0;
      end
      if (code_valid && code_ready === 1'b1) nb++;
      if (busy === 1'b1) begin
        bc++;
        chk("ready_busy", code_ready, 0);
      end
      if (done === 1'b1)
        chk("busy_len", bc, cur.cyc);
    end
  end

  // slow memory during the random phase
  always @(posedge clk_sys_in) stall <= rnd_on && ($urandom_range(3) == 0);

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    logic [7:0] corner[16];
    logic [7:0] spec[6];
    logic [7:0] rows[8];
    logic [31:0] rv;
    logic [3:0] r;
    logic [7:0] o;
    corner = '{8'h53, 8'h04, 8'hA4, 8'h84, 8'hA3, 8'hD4, 8'hE4, 8'hF4,
      8'h42, 8'h63, 8'h97, 8'h26, 8'h05, 8'h15, 8'h0F, 8'h34};
    spec = '{8'hA3, 8'hA4, 8'h84, 8'hD4, 8'hE4, 8'hF4};
    rows = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h9};
    void'($urandom(18233));
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    // back to back corner opcodes, negative and positive operands
    for (int i = 0; i < 16; i++)
      issue(corner[i], 8'h80 | i[7:0], 8'h0F + i[7:0]);
    drain();
    // reset in mid-fetch of a three byte instruction
    issue(8'h53, 8'h12, 8'h34);
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    exp_q.delete();
    @(negedge clk_sys_in);
    chk("rst_ready", code_ready, 1);
    chk("rst_valid", instr_valid, 0);
    chk("rst_busy", {busy, done}, 0);
    chk("rst_instr", io === '0, 1);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rnd_on <= 1'b1;
    // random legal arithmetic and logic forms with a slow memory
    for (int i = 0; i < 300; i++) begin
      rv = $urandom;
      r = rows[rv[18:16]][3:0];
      o = {r, 4'($urandom_range(15, (r >= 4'h4 && r <= 4'h6) ? 2 : 4))};
      if (rv[23:21] == 3'h0) o = spec[rv[26:24] % 6];
      issue(o, rv[7:0], rv[15:8]);
    end
    drain();
    stop_test();
  end
endmodule
